// ---- src/szd_pkg.sv ----
// Package with register map, field positions and types of the spindle zero-point block.
package szd_pkg;

  // Register byte addresses.
  localparam logic [7:0] ADDR_ZRN_SPEC    = 8'h00;
  localparam logic [7:0] ADDR_ORI_SHIFT   = 8'h04;
  localparam logic [7:0] ADDR_ZSRCH_SPEED = 8'h08;
  localparam logic [7:0] ADDR_SFUNC_FIVE  = 8'h0C;
  localparam logic [7:0] ADDR_SFUNC_SEVEN = 8'h10;
  localparam logic [7:0] ADDR_CONTROL     = 8'h14;
  localparam logic [7:0] ADDR_STATUS      = 8'h18;
  localparam logic [7:0] ADDR_MOTION      = 8'h1C;
  localparam logic [7:0] ADDR_STOP_POS    = 8'h20;

  // Reset values.
  localparam logic [15:0] RST_ZRN_SPEC    = 16'h0000;
  localparam logic [15:0] RST_ORI_SHIFT   = 16'h0000;
  localparam logic [15:0] RST_ZSRCH_SPEED = 16'h0000;
  localparam logic [15:0] RST_SFUNC_FIVE  = 16'h0000;
  localparam logic [15:0] RST_SFUNC_SEVEN = 16'h0000;

  // Field positions in the zero-return specification word.
  localparam int ZRN_PROX_EN     = 15;
  localparam int ZRN_NON_INTERP  = 14;
  localparam int ZRN_CAX_DIR_LO  = 9;
  localparam int ZRN_CAX_AUTO_N  = 8;
  localparam int ZRN_TAP_POL     = 7;
  localparam int ZRN_TAP_DIR_LO  = 5;
  localparam int ZRN_TAP_NO_RET  = 4;
  localparam int ZRN_ORI_DIR_LO  = 1;
  localparam int ZRN_ZDET_REV    = 0;
  // Enable-edge bit in spindle function word five.
  localparam int SF5_EDGE_RISE   = 5;
  // Input selection field in spindle function word seven.
  localparam int SF7_DIS_LO      = 12;
  localparam logic [3:0] DIS_NONE = 4'h0;
  localparam logic [3:0] DIS_PROX = 4'h4;

  // Control register bits.
  localparam int CTL_REDETECT_REQ = 0;
  localparam int CTL_SPEED_CMD    = 1;
  localparam int CTL_ORIENT_CMD   = 2;
  localparam int CTL_TAP_CMD      = 3;
  localparam int CTL_CAXIS_CMD    = 4;
  localparam int CTL_EMG_STOP     = 5;
  localparam int CTL_SERVO_OFF    = 6;

  // Orientation stop position limit in 0.01 degree units.
  localparam logic signed [16:0] SHIFT_MAX = 17'sd35999;
  localparam logic signed [16:0] SHIFT_MIN = -17'sd35999;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Rotation direction codes.
  typedef enum logic [1:0] {DIR_SHORT = 2'b00, DIR_FWD = 2'b01, DIR_REV = 2'b10,
                            DIR_BAD = 2'b11} szd_dir_t;

  // Motion command presented to the drive.
  typedef struct packed {
    logic        active;
    logic        nonInterp;
    szd_dir_t    dir;
    logic        tapReverse;
    logic [15:0] speed;
  } szd_motion_t;

endpackage

// ---- src/szd_zero_detect.sv ----
// Spindle zero-point detection with AXI4-Lite register access.
//
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps

module szd_zero_detect
  import szd_pkg::*;
(
  // Clock and reset.
  input  wire logic               clk,
  input  wire logic               arst_n,
  // AXI4-Lite slave.
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // Drive-side signals.
  input  wire logic               proxSwitch,
  input  wire logic               zPhasePulse,
  input  wire logic               posReached,
  input  wire logic signed [15:0] multiPointPos,
  output szd_motion_t             motion,
  output logic                    dropPrevent,
  output logic                    redetectComplete,
  output logic                    zPhasePassed,
  output logic signed [16:0]      stopPosition
);

  typedef enum {ST_IDLE, ST_SEARCH, ST_ORIENT, ST_TAP_RET, ST_CAX_RET} szd_state_t;

  logic [15:0] zeroReturnSpec;
  logic [15:0] oriShift;
  logic [15:0] zSearchSpeed;
  logic [15:0] spindleFuncFive;
  logic [15:0] spindleFuncSeven;
  logic [6:0]  control;
  logic        proxSync1;
  logic        proxSync2;
  logic        proxPrev;
  logic        zSync1;
  logic        zSync2;
  logic        zPrev;
  logic        proxEdge;
  logic        zEdge;
  logic        refEvent;
  logic        proxMode;
  logic        searched;
  logic        reqPrev;
  logic        cAxisPrev;
  logic        tapPrev;
  logic        orientPrev;
  logic        awHeld;
  logic        wHeld;
  logic [7:0]  awAddr;
  logic [31:0] wData;
  logic [3:0]  wStrb;
  logic [31:0] next_rdata;
  logic        next_rerr;
  logic        wrErr;
  logic signed [16:0] next_stop;
  szd_state_t  state;
  szd_motion_t next_motion;

  // Input synchronisers for the switch and the Z-phase pulse.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      proxSync1 <= 1'b0;
      proxSync2 <= 1'b0;
      proxPrev  <= 1'b0;
      zSync1    <= 1'b0;
      zSync2    <= 1'b0;
      zPrev     <= 1'b0;
    end else begin
      proxSync1 <= proxSwitch;
      proxSync2 <= proxSync1;
      proxPrev  <= proxSync2;
      zSync1    <= zPhasePulse;
      zSync2    <= zSync1;
      zPrev     <= zSync2;
    end
  end

  // Active switch edge is chosen by the enable-edge bit.
  assign proxEdge = spindleFuncFive[SF5_EDGE_RISE] ? (proxSync2 && !proxPrev)
                                                   : (!proxSync2 && proxPrev);
  assign zEdge    = zSync2 && !zPrev;
  // Proximity mode needs the enable bit and the proximity input selection.
  assign proxMode = zeroReturnSpec[ZRN_PROX_EN]
                    && (spindleFuncSeven[SF7_DIS_LO +: 4] == DIS_PROX);
  assign refEvent = proxMode ? proxEdge : zEdge;

  // AXI4-Lite write channel: address and data taken in either order.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      awAddr        <= 8'h00;
      wData         <= 32'h0000_0000;
      wStrb         <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !awHeld && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
      s_axi_wready  <= !wHeld && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (awHeld && wHeld) begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrErr ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    case (awAddr)
      ADDR_ZRN_SPEC, ADDR_ORI_SHIFT, ADDR_ZSRCH_SPEED, ADDR_SFUNC_FIVE,
      ADDR_SFUNC_SEVEN, ADDR_CONTROL: wrErr = 1'b0;
      default:                        wrErr = 1'b1;
    endcase
  end

  // Register file writes with byte lanes.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      zeroReturnSpec   <= RST_ZRN_SPEC;
      oriShift         <= RST_ORI_SHIFT;
      zSearchSpeed     <= RST_ZSRCH_SPEED;
      spindleFuncFive  <= RST_SFUNC_FIVE;
      spindleFuncSeven <= RST_SFUNC_SEVEN;
      control          <= 7'h00;
    end else if (awHeld && wHeld) begin
      for (int b = 0; b < 2; b++) begin
        if (wStrb[b]) begin
          case (awAddr)
            ADDR_ZRN_SPEC:    zeroReturnSpec[b*8 +: 8]   <= wData[b*8 +: 8];
            ADDR_ORI_SHIFT:   oriShift[b*8 +: 8]         <= wData[b*8 +: 8];
            ADDR_ZSRCH_SPEED: zSearchSpeed[b*8 +: 8]     <= wData[b*8 +: 8];
            ADDR_SFUNC_FIVE:  spindleFuncFive[b*8 +: 8]  <= wData[b*8 +: 8];
            ADDR_SFUNC_SEVEN: spindleFuncSeven[b*8 +: 8] <= wData[b*8 +: 8];
            default: ;
          endcase
        end
      end
      if (awAddr == ADDR_CONTROL && wStrb[0]) begin
        control <= wData[6:0];
      end
    end
  end

  // Read data multiplexer.
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rerr  = 1'b0;
    case (s_axi_araddr)
      ADDR_ZRN_SPEC:    next_rdata = {16'h0000, zeroReturnSpec};
      ADDR_ORI_SHIFT:   next_rdata = {16'h0000, oriShift};
      ADDR_ZSRCH_SPEED: next_rdata = {16'h0000, zSearchSpeed};
      ADDR_SFUNC_FIVE:  next_rdata = {16'h0000, spindleFuncFive};
      ADDR_SFUNC_SEVEN: next_rdata = {16'h0000, spindleFuncSeven};
      ADDR_CONTROL:     next_rdata = {25'h0000000, control};
      ADDR_STATUS:      next_rdata = {26'h0000000, proxMode, searched, dropPrevent,
                                      (state != ST_IDLE), redetectComplete, zPhasePassed};
      ADDR_MOTION:      next_rdata = {11'h000, motion};
      ADDR_STOP_POS:    next_rdata = {{15{stopPosition[16]}}, stopPosition};
      default:          next_rerr  = 1'b1;
    endcase
  end

  // AXI4-Lite read channel.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= next_rdata;
        s_axi_rresp  <= next_rerr ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Command edge memory.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reqPrev    <= 1'b0;
      cAxisPrev  <= 1'b0;
      tapPrev    <= 1'b0;
      orientPrev <= 1'b0;
    end else begin
      reqPrev    <= control[CTL_REDETECT_REQ];
      cAxisPrev  <= control[CTL_CAXIS_CMD];
      tapPrev    <= control[CTL_TAP_CMD];
      orientPrev <= control[CTL_ORIENT_CMD];
    end
  end

  // Motion sequencer.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
    end else if (control[CTL_EMG_STOP]) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (control[CTL_REDETECT_REQ] && !reqPrev) begin
            state <= ST_SEARCH;
          end else if (control[CTL_SPEED_CMD] && !searched) begin
            state <= ST_SEARCH;
          end else if (control[CTL_ORIENT_CMD] && !orientPrev) begin
            state <= ST_ORIENT;
          end else if (control[CTL_TAP_CMD] && !tapPrev
                       && !zeroReturnSpec[ZRN_TAP_NO_RET]) begin
            state <= ST_TAP_RET;
          end else if (control[CTL_CAXIS_CMD] && !cAxisPrev
                       && !zeroReturnSpec[ZRN_CAX_AUTO_N]) begin
            state <= ST_CAX_RET;
          end
        end
        ST_SEARCH: begin
          if (refEvent) begin
            state <= ST_IDLE;
          end
        end
        ST_ORIENT, ST_TAP_RET, ST_CAX_RET: begin
          if (posReached) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Reference flags and the re-detection handshake.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      searched         <= 1'b0;
      zPhasePassed     <= 1'b0;
      redetectComplete <= 1'b0;
    end else begin
      if (state == ST_SEARCH && refEvent) begin
        searched     <= 1'b1;
        zPhasePassed <= 1'b1;
      end else if (control[CTL_REDETECT_REQ] && !reqPrev) begin
        zPhasePassed <= 1'b0;
      end
      if (!control[CTL_REDETECT_REQ]) begin
        redetectComplete <= 1'b0;
      end else if (reqPrev && state == ST_SEARCH && refEvent) begin
        redetectComplete <= 1'b1;
      end
    end
  end

  // Motion command: direction per state, or the zero-detect direction in proximity mode; speed, gain mode and polarity from the registers.
  always_comb begin
    next_motion            = '0;
    next_motion.nonInterp  = zeroReturnSpec[ZRN_NON_INTERP];
    next_motion.tapReverse = zeroReturnSpec[ZRN_TAP_POL];
    next_motion.speed      = zSearchSpeed;
    case (state)
      ST_SEARCH: begin
        next_motion.active = 1'b1;
        next_motion.dir    = zeroReturnSpec[ZRN_ZDET_REV] ? DIR_REV : DIR_FWD;
      end
      ST_ORIENT: begin
        next_motion.active = 1'b1;
        next_motion.dir    = szd_dir_t'(zeroReturnSpec[ZRN_ORI_DIR_LO +: 2]);
      end
      ST_TAP_RET: begin
        next_motion.active = 1'b1;
        next_motion.dir    = szd_dir_t'(zeroReturnSpec[ZRN_TAP_DIR_LO +: 2]);
      end
      ST_CAX_RET: begin
        next_motion.active = 1'b1;
        next_motion.dir    = szd_dir_t'(zeroReturnSpec[ZRN_CAX_DIR_LO +: 2]);
      end
      default: ;
    endcase
    // The unused direction code falls back to the shortest path.
    if (next_motion.dir == DIR_BAD) begin
      next_motion.dir = DIR_SHORT;
    end
    if (proxMode && state != ST_IDLE) begin
      next_motion.dir = zeroReturnSpec[ZRN_ZDET_REV] ? DIR_REV : DIR_FWD;
    end
  end

  // Stop position is the shift plus the multi-point position, clamped.
  always_comb begin
    next_stop = 17'(signed'(oriShift)) + 17'(multiPointPos);
    if (next_stop > SHIFT_MAX) begin
      next_stop = SHIFT_MAX;
    end else if (next_stop < SHIFT_MIN) begin
      next_stop = SHIFT_MIN;
    end
  end

  // Registered outputs.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      motion       <= '0;
      dropPrevent  <= 1'b0;
      stopPosition <= 17'sd0;
    end else begin
      motion       <= next_motion;
      dropPrevent  <= control[CTL_EMG_STOP];
      stopPosition <= next_stop;
    end
  end

endmodule

// ---- dv/szd_far_side.sv ----
// Spindle and sensor model at the far side of the zero-point block.
`timescale 1ns/100ps
module szd_far_side
  import szd_pkg::*;
(
  // Clock, reset and move command.
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire szd_motion_t motion,
  // Sensor outputs.
  output logic             proxSwitch,
  output logic             zPhasePulse,
  output logic             posReached
);
  logic [5:0] angle;

  // The spindle turns only while a move is commanded.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      angle <= 6'h00;
    end else if (motion.active) begin
      angle <= (motion.dir == DIR_REV) ? angle - 6'h01 : angle + 6'h01;
    end
  end

  assign proxSwitch  = angle[5];
  assign zPhasePulse = angle[5:3] == 3'h2;
  assign posReached  = motion.active && angle[3:0] == 4'hF;
endmodule

// ---- dv/szd_zero_detect_chk.sv ----
// Assertion checker for the spindle zero-point block.
`timescale 1ns/100ps
module szd_zero_detect_chk
  import szd_pkg::*;
(
  // Clock and reset.
  input wire logic               clk,
  input wire logic               arst_n,
  // Bus answers.
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wready,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_arready,
  input wire logic               s_axi_rvalid,
  input wire logic [1:0]         s_axi_rresp,
  input wire logic [31:0]        s_axi_rdata,
  // Drive side.
  input wire szd_motion_t        motion,
  input wire logic               dropPrevent,
  input wire logic               redetectComplete,
  input wire logic               zPhasePassed,
  input wire logic signed [16:0] stopPosition
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("write address ready held too long");
  a_write_resp: assert property (s_axi_awready && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  a_read_resp: assert property (s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 0)
    else $error("error read carries data");
  a_stop_range: assert property (stopPosition <= SHIFT_MAX && stopPosition >= SHIFT_MIN)
    else $error("stop position out of range");
  a_dir_legal: assert property (motion.active |-> motion.dir != DIR_BAD)
    else $error("illegal move direction");
  a_done_pass: assert property (redetectComplete |-> zPhasePassed)
    else $error("complete without zero passed");
  a_done_rise: assert property ($rose(redetectComplete) |-> $rose(zPhasePassed))
    else $error("complete rose apart from zero passed");
  a_drop_abort: assert property ($rose(dropPrevent) |-> ##[0:2] !motion.active)
    else $error("move kept during emergency stop");
endmodule

bind szd_zero_detect szd_zero_detect_chk chk (
  .clk(clk), .arst_n(arst_n), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rresp(s_axi_rresp), .s_axi_rdata(s_axi_rdata), .motion(motion),
  .dropPrevent(dropPrevent), .redetectComplete(redetectComplete),
  .zPhasePassed(zPhasePassed), .stopPosition(stopPosition)
);

// ---- dv/test_szd_zero_detect.sv ----
// Self-checking testbench of the spindle zero-point block.
`timescale 1ns/100ps
module test_szd_zero_detect
  import szd_pkg::*;
;
  logic               clk = 1'b0;
  logic               arst_n = 1'b0;
  logic [7:0]         s_axi_awaddr = 8'h00;
  logic [7:0]         s_axi_araddr = 8'h00;
  logic               s_axi_awvalid = 1'b0;
  logic               s_axi_wvalid = 1'b0;
  logic               s_axi_arvalid = 1'b0;
  logic               s_axi_bready = 1'b1;
  logic               s_axi_rready = 1'b1;
  logic [31:0]        s_axi_wdata = 32'h0;
  logic [3:0]         s_axi_wstrb = 4'hF;
  logic signed [15:0] multiPointPos = 16'h0000;
  logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]         s_axi_bresp, s_axi_rresp;
  logic [31:0]        s_axi_rdata, d;
  logic               proxSwitch, zPhasePulse, posReached, dropPrevent;
  logic               redetectComplete, zPhasePassed;
  szd_motion_t        motion;
  logic signed [16:0] stopPosition;
  logic [1:0]         r;
  logic               act;
  logic [15:0]        seed = 16'h351D, spec;
  logic signed [15:0] sh, mp;
  int                 err_count = 0, num_checks = 0, cycles = 0;
  localparam logic [7:0] REGS [5] = '{ADDR_ZRN_SPEC, ADDR_ORI_SHIFT, ADDR_ZSRCH_SPEED,
                                      ADDR_SFUNC_FIVE, ADDR_SFUNC_SEVEN};

  always #4 clk = ~clk;

  szd_zero_detect uut (
    .clk(clk), .arst_n(arst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .proxSwitch(proxSwitch),
    .zPhasePulse(zPhasePulse), .posReached(posReached), .multiPointPos(multiPointPos),
    .motion(motion), .dropPrevent(dropPrevent), .redetectComplete(redetectComplete),
    .zPhasePassed(zPhasePassed), .stopPosition(stopPosition)
  );
  szd_far_side far (
    .clk(clk), .arst_n(arst_n), .motion(motion), .proxSwitch(proxSwitch),
    .zPhasePulse(zPhasePulse), .posReached(posReached)
  );

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  function automatic logic signed [16:0] clampSum(input logic signed [15:0] a, b);
    logic signed [16:0] s;
    s = a + b;
    if (s > SHIFT_MAX) s = SHIFT_MAX;
    if (s < SHIFT_MIN) s = SHIFT_MIN;
    return s;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw = 1'b0;
    logic w = 1'b0;
    logic b = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!b) begin
      @(negedge clk);
      aw = s_axi_awready;
      w = s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] a);
    logic ar = 1'b0;
    logic b = 1'b0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!b) begin
      @(negedge clk);
      ar = s_axi_arready;
      b = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
  endtask

  task automatic runCmd(input int b, input szd_dir_t dir, input logic f, input logic [15:0] sp);
    wr(ADDR_CONTROL, 32'h1 << b);
    for (int n = 0; n < 100 && motion.active !== 1'b1; n++) @(posedge clk);
    chk("busy", motion.active, 1'b1);
    chk("dir", motion.dir, dir);
    if (sp != 0) chk("speed", motion.speed, sp);
    if (b == CTL_ORIENT_CMD) chk("gain", motion.nonInterp, f);
    if (b == CTL_TAP_CMD) chk("tap", motion.tapReverse, f);
    for (int n = 0; n < 200 && motion.active === 1'b1; n++) @(posedge clk);
    chk("done", motion.active, 1'b0);
    wr(ADDR_CONTROL, 32'h0);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_count++;
      final_report;
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(REGS[i]);
      chk("reset", d, 32'h0);
      seed = lfsr(seed);
      wr(REGS[i], {16'h0, seed});
      rd(REGS[i]);
      chk("readback", d, {16'h0, seed});
    end
    rd(8'hFC);
    chk("unmapped", r, RESP_SLVERR);
    wr(8'hFC, 32'hFFFF);
    chk("unmapped", r, RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      sh = (i == 0) ? 16'h7FFF : (i == 1) ? 16'h8000 : seed;
      mp = (i < 2) ? sh : lfsr(seed);
      wr(ADDR_ORI_SHIFT, {16'h0, sh});
      multiPointPos <= mp;
      repeat (3) @(posedge clk);
      chk("stop", stopPosition, clampSum(sh, mp));
    end
    wr(ADDR_ZRN_SPEC, 32'h0);
    wr(ADDR_SFUNC_SEVEN, 32'h0);
    wr(ADDR_ZSRCH_SPEED, 32'h0123);
    runCmd(CTL_SPEED_CMD, DIR_FWD, 1'b0, 16'h0123);
    chk("passed", zPhasePassed, 1'b1);
    for (int i = 0; i < 3; i++) begin
      spec = 16'((i << 1) | (i << 5) | (i << 9) | (i[0] << 7) | (i[0] << 14));
      wr(ADDR_ZRN_SPEC, {16'h0, spec});
      runCmd(CTL_ORIENT_CMD, szd_dir_t'(i), i[0], 16'h0);
      runCmd(CTL_TAP_CMD, szd_dir_t'(i), i[0], 16'h0);
      runCmd(CTL_CAXIS_CMD, szd_dir_t'(i), 1'b0, 16'h0);
    end
    wr(ADDR_ZRN_SPEC, 32'h0110);
    wr(ADDR_CONTROL, 32'h18);
    act = 1'b0;
    repeat (8) begin
      @(posedge clk);
      act = act | motion.active;
    end
    chk("skip", act, 1'b0);
    wr(ADDR_CONTROL, 32'h0);
    wr(ADDR_SFUNC_SEVEN, {16'h0, DIS_PROX, 12'h000});
    wr(ADDR_ZRN_SPEC, 32'h8003);
    runCmd(CTL_ORIENT_CMD, DIR_REV, 1'b0, 16'h0123);
    runCmd(CTL_TAP_CMD, DIR_REV, 1'b0, 16'h0123);
    for (int e = 1; e >= 0; e--) begin
      wr(ADDR_SFUNC_FIVE, 32'(e) << SF5_EDGE_RISE);
      wr(ADDR_CONTROL, 32'h1);
      for (int n = 0; n < 50 && zPhasePassed !== 1'b0; n++) @(posedge clk);
      chk("cleared", zPhasePassed, 1'b0);
      for (int n = 0; n < 400 && redetectComplete !== 1'b1; n++) @(posedge clk);
      chk("complete", redetectComplete, 1'b1);
      chk("passed", zPhasePassed, 1'b1);
      chk("edge", proxSwitch, e[0]);
      wr(ADDR_CONTROL, 32'h0);
      repeat (2) @(posedge clk);
      chk("complete", redetectComplete, 1'b0);
    end
    wr(ADDR_CONTROL, 32'h1);
    wr(ADDR_CONTROL, 32'h21);
    repeat (2) @(posedge clk);
    chk("drop", dropPrevent, 1'b1);
    chk("abort", motion.active, 1'b0);
    wr(ADDR_CONTROL, 32'h1 << CTL_SERVO_OFF);
    repeat (2) @(posedge clk);
    chk("drop", dropPrevent, 1'b0);
    final_report;
  end
endmodule
